// ---- design/ep_pulse_ctrl.sv ----
// Energy pulse output control with AXI4-Lite register access
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps

// Contract
// RULE_01: The LED mode picks off (dark), alarm (follows alarm notice) or energy (pulses).
// RULE_02: In energy mode a programmed count of 1 to 9999999 pulses is sent per whole unit.
// RULE_03: In alarm mode the pulse rate and the channel choice have no effect on the LED.
// RULE_04: Pulses come from one chosen channel of nine: three kinds, each del, rec or both.
// RULE_05: On fixed-function variants the LED stays in energy mode and other modes are refused.
// RULE_06: A digital output in energy mode follows the pulses; in external mode it does not.
// RULE_07: In external mode a digital output only follows on and off commands from afar.
// RULE_08: Selected energy is summed and one fixed pulse fires per unit over count, residue kept; the code drops the pulse once 255 are pending.
module ep_pulse_ctrl #(
    parameter bit FIXED_FUNC = 1'b0,
    parameter int PULSE_CYC = ep_pkg::EP_PULSE_CYC,
    parameter int UNIT_Q = ep_pkg::EP_UNIT_Q
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire ep_pkg::ep_axi_req_s axi_req,
    output ep_pkg::ep_axi_rsp_s axi_rsp,
    // Measurement and alarm side
    input wire logic energy_valid,
    input wire ep_pkg::ep_energy_s energy_inc,
    input wire logic alarm_active,
    // Indicator and digital outputs
    output logic led_out,
    output logic [ep_pkg::EP_NDO-1:0] dout_out
);
    import ep_pkg::*;

    localparam logic [EP_ACC_W-1:0] UNIT_ACC = EP_ACC_W'(UNIT_Q);
    localparam logic [15:0] PW = 16'(PULSE_CYC);

    ep_state_s s_q;
    ep_state_s s_d;
    logic [EP_EW:0] inc_sel;
    logic [EP_EW+24:0] prod;
    logic [EP_ACC_W-1:0] acc_sum;
    logic do_wr;
    logic do_rd;
    logic [31:0] wval;
    logic [31:0] ctrl_rd;

    // Byte-lane merge of write data onto an old register value
    function automatic logic [31:0] ep_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : ep_merge

    // Increment of one energy channel: kind is code/3, direction code%3
    function automatic logic [EP_EW:0] ep_chan_inc(input logic [3:0] ch, input ep_energy_s e);
        logic [1:0] kind;
        logic [1:0] dir;
        kind = 2'(ch / 4'h3);
        dir = 2'(ch % 4'h3);
        if (kind > 2'h2) begin
            return '0;
        end
        unique case (dir)
            2'h0: return {1'b0, e.del[kind]};
            2'h1: return {1'b0, e.rec[kind]};
            default: return {1'b0, e.del[kind]} + {1'b0, e.rec[kind]};
        endcase
    endfunction : ep_chan_inc

    // Control register image
    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[EP_LMODE_LSB +: 2] = s_q.led_mode;
        ctrl_rd[EP_CHAN_LSB +: 4] = s_q.chan;
        ctrl_rd[EP_DMODE_LSB +: EP_NDO] = s_q.do_mode;
    end

    // Next state of the whole block
    always_comb begin
        s_d = s_q;
        inc_sel = ep_chan_inc(s_q.chan, energy_inc); // [RULE_04]
        prod = inc_sel * s_q.rate;
        acc_sum = s_q.acc;
        wval = '0;

        // Write address and data taken in either order
        if (axi_req.awvalid && s_q.rsp.awready) begin
            s_d.aw_hold = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_q.rsp.wready) begin
            s_d.w_hold = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (s_q.rsp.bvalid && axi_req.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        do_wr = s_q.aw_hold && s_q.w_hold && !s_q.rsp.bvalid;

        // Register writes
        if (do_wr) begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = EP_RESP_OKAY;
            unique case (s_q.aw_addr)
                EP_CTRL_OFS: begin
                    wval = ep_merge(ctrl_rd, s_q.w_data, s_q.w_strb);
                    if (FIXED_FUNC) begin
                        s_d.led_mode = EP_LED_ENERGY; // [RULE_05]
                    end else if (wval[EP_LMODE_LSB +: 2] <= EP_LED_ENERGY) begin
                        s_d.led_mode = wval[EP_LMODE_LSB +: 2]; // [RULE_01]
                    end
                    if (wval[EP_CHAN_LSB +: 4] <= EP_CH_LAST) begin
                        s_d.chan = wval[EP_CHAN_LSB +: 4]; // [RULE_04]
                    end
                    s_d.do_mode = wval[EP_DMODE_LSB +: EP_NDO]; // [RULE_06]
                end
                EP_RATE_OFS: begin
                    wval = ep_merge({8'h00, s_q.rate}, s_q.w_data, s_q.w_strb);
                    if (wval[31:24] == 8'h00 && wval[23:0] >= EP_RATE_MIN
                        && wval[23:0] <= EP_RATE_MAX) begin
                        s_d.rate = wval[23:0]; // [RULE_02]
                    end
                end
                EP_DCMD_OFS: begin
                    wval = ep_merge({{(32-EP_NDO){1'b0}}, s_q.do_cmd}, s_q.w_data, s_q.w_strb);
                    s_d.do_cmd = wval[EP_NDO-1:0]; // [RULE_07]
                end
                EP_STAT_OFS: begin
                    s_d.rsp.bresp = EP_RESP_OKAY;
                end
                default: begin
                    s_d.rsp.bresp = EP_RESP_SLVERR;
                end
            endcase
        end

        // Register reads
        if (s_q.rsp.rvalid && axi_req.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        do_rd = axi_req.arvalid && s_q.rsp.arready;
        if (do_rd) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rresp = EP_RESP_OKAY;
            s_d.rsp.rdata = '0;
            unique case (axi_req.araddr)
                EP_CTRL_OFS: s_d.rsp.rdata = ctrl_rd;
                EP_RATE_OFS: s_d.rsp.rdata = {8'h00, s_q.rate};
                EP_DCMD_OFS: s_d.rsp.rdata = {{(32-EP_NDO){1'b0}}, s_q.do_cmd};
                EP_STAT_OFS: begin
                    s_d.rsp.rdata[0] = s_q.led;
                    s_d.rsp.rdata[EP_ST_DOUT_LSB +: EP_NDO] = s_q.dout;
                    s_d.rsp.rdata[EP_ST_PEND_LSB +: 8] = s_q.pend;
                    s_d.rsp.rdata[EP_ST_CNT_LSB +: 16] = s_q.pcnt;
                end
                default: s_d.rsp.rresp = EP_RESP_SLVERR;
            endcase
        end

        // Ready flags, registered so the bus sees flip-flops
        s_d.rsp.awready = !s_d.aw_hold && !s_d.rsp.bvalid;
        s_d.rsp.wready = !s_d.w_hold && !s_d.rsp.bvalid;
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // Energy accumulation, one unit removed per cycle, residue kept
        if (energy_valid) begin
            acc_sum = s_q.acc + {{(EP_ACC_W-EP_EW-25){1'b0}}, prod}; // [RULE_02] [RULE_08]
        end
        if (acc_sum >= UNIT_ACC) begin
            s_d.acc = acc_sum - UNIT_ACC; // [RULE_08]
            if (s_q.pend != 8'hFF) begin
                s_d.pend = s_q.pend + 8'h01;
            end
        end else begin
            s_d.acc = acc_sum;
        end

        // Fixed-width pulse: high PW cycles, then low PW cycles
        if (s_q.ph_cnt != 16'h0000) begin
            s_d.ph_cnt = s_q.ph_cnt - 16'h0001;
            if (s_q.ph_cnt == PW) begin
                s_d.pulse = 1'b0;
            end
        end else if (s_d.pend != 8'h00) begin
            s_d.pend = s_d.pend - 8'h01; // [RULE_08]
            s_d.pulse = 1'b1;
            s_d.ph_cnt = PW + PW - 16'h0001;
            s_d.pcnt = s_q.pcnt + 16'h0001;
        end

        // LED source by mode; alarm ignores rate and channel
        unique case (s_q.led_mode)
            EP_LED_ALARM: s_d.led = alarm_active; // [RULE_01] [RULE_03]
            EP_LED_ENERGY: s_d.led = s_q.pulse; // [RULE_01]
            default: s_d.led = 1'b0; // [RULE_01]
        endcase

        // Digital outputs: pulses or remote commands
        for (int i = 0; i < EP_NDO; i++) begin
            s_d.dout[i] = (s_q.do_mode[i] == EP_DO_ENERGY) ? s_q.pulse : s_q.do_cmd[i]; // [RULE_06] [RULE_07]
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.led_mode <= FIXED_FUNC ? EP_LED_ENERGY : EP_LMODE_RST; // [RULE_05]
            s_q.chan <= EP_CHAN_RST;
            s_q.rate <= EP_RATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign axi_rsp = s_q.rsp;
    assign led_out = s_q.led;
    assign dout_out = s_q.dout;
endmodule : ep_pulse_ctrl

// ---- design/ep_pkg.sv ----
// Shared constants and carriers for the energy pulse output control block
package ep_pkg;
    // Register byte offsets
    localparam logic [7:0] EP_CTRL_OFS = 8'h00;
    localparam logic [7:0] EP_RATE_OFS = 8'h04;
    localparam logic [7:0] EP_DCMD_OFS = 8'h08;
    localparam logic [7:0] EP_STAT_OFS = 8'h0C;
    // Control register field positions
    localparam int EP_LMODE_LSB = 0;
    localparam int EP_CHAN_LSB = 4;
    localparam int EP_DMODE_LSB = 8;
    // Status register field positions
    localparam int EP_ST_DOUT_LSB = 1;
    localparam int EP_ST_PEND_LSB = 8;
    localparam int EP_ST_CNT_LSB = 16;
    // LED mode codes
    localparam logic [1:0] EP_LED_OFF = 2'h0;
    localparam logic [1:0] EP_LED_ALARM = 2'h1;
    localparam logic [1:0] EP_LED_ENERGY = 2'h2;
    // Digital output mode codes
    localparam logic EP_DO_EXTERNAL = 1'b0;
    localparam logic EP_DO_ENERGY = 1'b1;
    // Energy channel codes, nine in all
    localparam logic [3:0] EP_CH_LAST = 4'h8;
    // Pulse rate range, pulses per unit of energy
    localparam logic [23:0] EP_RATE_MIN = 24'h000001;
    localparam logic [23:0] EP_RATE_MAX = 24'h98967F;
    // Reset values
    localparam logic [1:0] EP_LMODE_RST = EP_LED_OFF;
    localparam logic [3:0] EP_CHAN_RST = 4'h0;
    localparam logic [23:0] EP_RATE_RST = 24'h000001;
    // Widths
    localparam int EP_NDO = 2;
    localparam int EP_EW = 16;
    localparam int EP_ACC_W = 48;
    // Pulse timing: high time in microseconds, equal low gap after it
    localparam int EP_CLK_MHZ = 20;
    localparam int EP_PULSE_US = 10;
    localparam int EP_PULSE_CYC = EP_PULSE_US * EP_CLK_MHZ;
    // Energy quanta that make one whole kWh, kVARh or kVAh
    localparam int EP_UNIT_Q = 1000000;
    // AXI responses
    localparam logic [1:0] EP_RESP_OKAY = 2'h0;
    localparam logic [1:0] EP_RESP_SLVERR = 2'h2;

    // Energy increments, one per kind, delivered and received
    typedef struct packed {
        logic [2:0][EP_EW-1:0] del;
        logic [2:0][EP_EW-1:0] rec;
    } ep_energy_s;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } ep_axi_req_s;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ep_axi_rsp_s;

    // Whole state of the block
    typedef struct packed {
        ep_axi_rsp_s rsp;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [1:0] led_mode;
        logic [3:0] chan;
        logic [EP_NDO-1:0] do_mode;
        logic [23:0] rate;
        logic [EP_NDO-1:0] do_cmd;
        logic [EP_ACC_W-1:0] acc;
        logic [7:0] pend;
        logic [15:0] pcnt;
        logic [15:0] ph_cnt;
        logic pulse;
        logic led;
        logic [EP_NDO-1:0] dout;
    } ep_state_s;
endpackage : ep_pkg

// ---- sim/ep_pulse_cnt.sv ----
// Pulse counting equipment watching the indicator and digital outputs
`timescale 1ns/100ps
module ep_pulse_cnt (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watched lines and rising edges seen
    input wire logic [2:0] line,
    output logic [2:0][15:0] count_q
);
    logic [2:0] line_q;
    // Counts each rising edge
    always_ff @(posedge aclk) begin
        line_q <= line;
        for (int i = 0; i < 3; i++) begin
            if (!aresetn) begin
                count_q[i] <= 16'h0000;
            end else if (line[i] && !line_q[i]) begin
                count_q[i] <= count_q[i] + 16'h0001;
            end
        end
    end
endmodule : ep_pulse_cnt

// ---- sim/ep_pulse_ctrl_sva.sv ----
// Checker for the energy pulse output control block
`timescale 1ns/100ps
module ep_pulse_ctrl_sva
    import ep_pkg::*;
#(
    parameter bit FIXED_FUNC = 1'b0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire ep_pkg::ep_axi_req_s axi_req,
    input wire ep_pkg::ep_axi_rsp_s axi_rsp,
    // Measurement side and outputs
    input wire logic energy_valid,
    input wire ep_pkg::ep_energy_s energy_inc,
    input wire logic alarm_active,
    input wire logic led_out,
    input wire logic [ep_pkg::EP_NDO-1:0] dout_out
);
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [1:0] mode_q;
    logic [1:0] dom_q;
    logic [1:0] dcmd_q;
    // Mirror of settings, one cycle behind the block
    always_ff @(posedge aclk) begin
        if (axi_req.awvalid && axi_rsp.awready) aw_q <= axi_req.awaddr;
        if (axi_req.wvalid && axi_rsp.wready) w_q <= axi_req.wdata;
        if (!aresetn) begin
            mode_q <= FIXED_FUNC ? EP_LED_ENERGY : EP_LED_OFF;
            dom_q <= 2'h0;
            dcmd_q <= 2'h0;
        end else if (axi_rsp.bvalid && axi_req.bready) begin
            if (!FIXED_FUNC && aw_q == EP_CTRL_OFS && w_q[1:0] != 2'h3) mode_q <= w_q[1:0];
            if (aw_q == EP_CTRL_OFS) dom_q <= w_q[9:8];
            if (aw_q == EP_DCMD_OFS) dcmd_q <= w_q[1:0];
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    led_dark_a: assert property ((mode_q == EP_LED_OFF) [*2] |-> !led_out)
        else $error("led lit while off");
    led_alarm_a: assert property ((mode_q == EP_LED_ALARM) [*2] |-> led_out == $past(alarm_active))
        else $error("led not following alarm");
    pulse_shape_a: assert property ((mode_q == EP_LED_ENERGY) && $rose(led_out) |-> led_out [*4] ##1 !led_out [*4])
        else $error("pulse width or gap wrong");
    dout_energy_a: assert property ((dom_q[1] && mode_q == EP_LED_ENERGY) [*2] |-> dout_out[1] == led_out)
        else $error("energy output not pulsing");
    dout_remote_a: assert property ((!dom_q[0]) [*2] |-> dout_out[0] == dcmd_q[0])
        else $error("external output not under command");
    wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid)
        else $error("write answer late");
    wr_busy_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write ready during answer");
    rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read answer wrong");
    rd_unmapped_a: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr > EP_STAT_OFS |=> axi_rsp.rresp == EP_RESP_SLVERR && axi_rsp.rdata == 32'h0)
        else $error("unmapped read not refused");
    cover property ((mode_q == EP_LED_ENERGY) && $rose(led_out));
    cover property ((mode_q == EP_LED_ALARM) && led_out);
    cover property (!dom_q[0] && dout_out[0]);
endmodule : ep_pulse_ctrl_sva
bind ep_pulse_ctrl ep_pulse_ctrl_sva #(.FIXED_FUNC(FIXED_FUNC)) ep_pulse_ctrl_sva_inst (.aclk,
    .aresetn, .axi_req, .axi_rsp,
    .energy_valid, .energy_inc, .alarm_active, .led_out, .dout_out);

// ---- sim/ep_pulse_ctrl_tb.sv ----
// Testbench for the energy pulse output control block
`timescale 1ns/100ps
module ep_pulse_ctrl_tb;
    import ep_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    ep_axi_req_s req;
    ep_axi_rsp_s rsp;
    logic ev;
    ep_energy_s inc;
    logic alarm;
    logic led;
    logic [1:0] dout;
    logic [2:0][15:0] cnt;
    ep_axi_rsp_s rsp_fix;
    logic led_fix;
    logic [1:0] dout_fix;
    logic [2:0][15:0] cnt_fix;
    logic [1:0] wr_resp;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    ep_pulse_ctrl #(.FIXED_FUNC(1'b0), .PULSE_CYC(4), .UNIT_Q(100)) ep_pulse_ctrl_inst (.aclk,
        .aresetn, .axi_req(req), .axi_rsp(rsp), .energy_valid(ev), .energy_inc(inc),
        .alarm_active(alarm), .led_out(led), .dout_out(dout));
    ep_pulse_cnt ep_pulse_cnt_inst (.aclk, .aresetn, .line({dout, led}), .count_q(cnt));
    // Fixed-function variant on the same bus and energy feed, answers watched apart
    ep_pulse_ctrl #(.FIXED_FUNC(1'b1), .PULSE_CYC(4), .UNIT_Q(100)) ep_pulse_ctrl_fix_inst (.aclk,
        .aresetn, .axi_req(req), .axi_rsp(rsp_fix), .energy_valid(ev), .energy_inc(inc),
        .alarm_active(alarm), .led_out(led_fix), .dout_out(dout_fix));
    ep_pulse_cnt ep_pulse_cnt_fix_inst (.aclk, .aresetn, .line({dout_fix, led_fix}),
        .count_q(cnt_fix));
    always #25 aclk = ~aclk;
    // Cuts a hang short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            $display("Error at %0t: timeout", $time);
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        wr_resp = rsp.bresp;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        chk(rsp.rdata, e);
        chk({30'h0, rsp.rresp}, {30'h0, er});
    endtask : rdc
    // Energy for some cycles, then time for pending pulses to drain
    task automatic feed(input int n);
        ev <= 1'b1;
        repeat (n) @(posedge aclk);
        ev <= 1'b0;
        repeat (60) @(posedge aclk);
    endtask : feed
    task automatic finish_test();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    initial begin
        int res;
        int q;
        int tot;
        logic [15:0] n1;
        logic [15:0] n0;
        logic [15:0] d0;
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        req.wstrb = 4'hF;
        ev = 1'b0;
        alarm = 1'b0;
        res = 0;
        tot = 0;
        for (int k = 0; k < 3; k++) begin
            inc.del[k] = 16'(k + 2);
            inc.rec[k] = 16'(k + 5);
        end
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(EP_CTRL_OFS, 32'h0, EP_RESP_OKAY);
        chk(rsp_fix.rdata, 32'h2);
        rdc(EP_STAT_OFS, 32'h0, EP_RESP_OKAY);
        rdc(EP_RATE_OFS, 32'h1, EP_RESP_OKAY);
        rdc(8'h10, 32'h0, EP_RESP_SLVERR);
        wr(8'h10, 32'h1);
        chk({30'h0, wr_resp}, {30'h0, EP_RESP_SLVERR});
        wr(EP_RATE_OFS, 32'h0);
        chk({30'h0, wr_resp}, {30'h0, EP_RESP_OKAY});
        rdc(EP_RATE_OFS, 32'h1, EP_RESP_OKAY);
        wr(EP_RATE_OFS, 32'h0098_9680);
        rdc(EP_RATE_OFS, 32'h1, EP_RESP_OKAY);
        wr(EP_RATE_OFS, 32'h0098_967F);
        rdc(EP_RATE_OFS, 32'h0098_967F, EP_RESP_OKAY);
        wr(EP_RATE_OFS, 32'h3);
        // Every channel in turn, residue carried over
        for (int c = 0; c < 9; c++) begin
            wr(EP_CTRL_OFS, {22'h0, 2'h3, 4'(c), 2'h0, EP_LED_ENERGY});
            q = (c % 3 == 1 ? 0 : c / 3 + 2) + (c % 3 == 0 ? 0 : c / 3 + 5);
            res = res + 30 * q;
            n0 = cnt[0];
            d0 = cnt[2];
            feed(10);
            chk(32'(cnt[0] - n0), 32'(res / 100));
            chk(32'(cnt[2] - d0), 32'(res / 100));
            tot = tot + res / 100;
            res = res % 100;
            rdc(EP_STAT_OFS, {16'(tot), 16'h0000}, EP_RESP_OKAY);
        end
        wr(EP_CTRL_OFS, 32'h0000_0093);
        rdc(EP_CTRL_OFS, 32'h0000_0082, EP_RESP_OKAY);
        wr(EP_CTRL_OFS, {24'h0, 4'h5, 2'h0, EP_LED_ALARM});
        rdc(EP_CTRL_OFS, 32'h0000_0051, EP_RESP_OKAY);
        chk(rsp_fix.rdata, 32'h0000_0052);
        n0 = cnt[0];
        ev <= 1'b1;
        repeat (2) begin
            alarm <= 1'b1;
            repeat (3) @(posedge aclk);
            alarm <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        feed(1);
        chk(32'(cnt[0] - n0), 32'h2);
        // Thirteen energy edges at rate 3 on a channel worth 9 quanta
        res = (res + 13 * 3 * 9) % 100;
        wr(EP_DCMD_OFS, 32'h1);
        d0 = cnt[2];
        feed(10);
        chk({30'h0, dout}, 32'h1);
        chk(32'(cnt[2] - d0), 32'h0);
        res = (res + 30 * 9) % 100;
        wr(EP_DCMD_OFS, 32'h0);
        wr(EP_CTRL_OFS, 32'h0);
        n0 = cnt[0];
        n1 = cnt_fix[0];
        feed(10);
        chk(32'(cnt[0] - n0), 32'h0);
        chk(32'(cnt_fix[0] - n1), 32'((res + 60) / 100));
        finish_test();
    end
endmodule : ep_pulse_ctrl_tb
